// File: inc/pmcc_pkg.sv
// shared constants and types for the pm event enable and cpu clock control block
package pmcc_pkg;

  // ==========================================================================
  // register offsets from the power-management i/o base
  // ==========================================================================
  localparam logic [7:0] PMCC_OFS_STATUS_DW = 8'h0C; // dword that holds the enable half
  localparam logic [7:0] PMCC_OFS_WAKE_EN = 8'h0E;
  localparam logic [7:0] PMCC_OFS_CLK_CTRL = 8'h10;
  localparam logic [7:0] PMCC_OFS_LEVEL_TWO_ENTRY = 8'h14;
  localparam logic [7:0] PMCC_OFS_LEVEL_THREE_ENTRY = 8'h15;

  // ==========================================================================
  // wake_event_enable fields
  // ==========================================================================
  localparam int PMCC_WE_COVER_BIT = 11;
  localparam int PMCC_WE_RING_BIT = 10;
  localparam int PMCC_WE_GPIN_BIT = 9;
  localparam int PMCC_WE_SBUS_BIT = 8;
  localparam int PMCC_WE_THERM_BIT = 0;
  localparam logic [15:0] PMCC_WAKE_EN_MASK = 16'h0F01;
  localparam logic [15:0] PMCC_WAKE_EN_RESET = 16'h0000;

  // ==========================================================================
  // processor_clock_control fields
  // ==========================================================================
  localparam int PMCC_PC_ACTIVE_BIT = 17;
  localparam int PMCC_PC_PCI_STOP_BIT = 13;
  localparam int PMCC_PC_HALT_BIT = 12;
  localparam int PMCC_PC_SLEEP_BIT = 11;
  localparam int PMCC_PC_BURST_BIT = 10;
  localparam int PMCC_PC_CLOCK_CTRL_ENABLE_BIT = 9;
  localparam int PMCC_PC_THROTTLE_BIT = 4;
  localparam int PMCC_PC_DUTY_LSB = 1;
  localparam logic [31:0] PMCC_CLK_CTRL_WMASK = 32'h0000_3E1E;
  localparam logic [31:0] PMCC_CLK_CTRL_RESET = 32'h0000_0000;

  // ==========================================================================
  // counts
  // ==========================================================================
  localparam logic [4:0] PMCC_PCI_IDLE_CLOCKS = 5'h1A; // 26 idle bus clocks
  localparam int PMCC_THROTTLE_SLOTS = 8;
  localparam int PMCC_SLOT_CYCLES_DEFAULT = 16;

  // ==========================================================================
  // event sources, index 0 = thermal .. 4 = cover switch
  // ==========================================================================
  localparam int PMCC_NUM_SRC = 5;
  localparam int PMCC_SRC_BIT [PMCC_NUM_SRC] = '{0, 8, 9, 10, 11};
  localparam logic [4:0] PMCC_SRC_CAN_INT = 5'h15; // thermal, gp input, cover
  localparam logic [4:0] PMCC_SRC_CAN_RSM = 5'h1E; // all but thermal

  // status flags from the status register, msb = cover switch
  typedef struct packed {
    logic cover_switch_status_flag;
    logic ring_status_flag;
    logic gp_input_status_flag;
    logic serial_bus_resume_flag;
    logic thermal_status_flag;
  } pmcc_status_t;

  // i/o request and answer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] offset;
    logic [3:0] be;
    logic [31:0] wdata;
  } pmcc_io_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } pmcc_io_rsp_t;

  typedef enum logic [2:0] {
    PMCC_CC_RUN = 3'b001,
    PMCC_CC_LEVEL_TWO_ENTRY = 3'b010,
    PMCC_CC_LEVEL_THREE_ENTRY = 3'b100
  } pmcc_cc_state_t;

  typedef enum logic [2:0] {
    PMCC_CR_HOLD = 3'b001,
    PMCC_CR_REQ = 3'b010,
    PMCC_CR_STOP = 3'b100
  } pmcc_cr_state_t;

endpackage

// File: verilog/pmcc_throttle.sv
// stop-clock throttle generator with eight equal slots per period
`timescale 1ns/100ps
module pmcc_throttle
  import pmcc_pkg::*;
#(
  parameter int SLOT_CYCLES = PMCC_SLOT_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] duty_i,
  // output
  output logic halt_o
);

  localparam int CW = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;
  localparam logic [CW-1:0] SLOT_LAST = CW'(SLOT_CYCLES - 1);

  // ==========================================================================
  // parameter check
  // ==========================================================================
  if (SLOT_CYCLES < 1) begin : g_bad_slot
    $error("pmcc_throttle: SLOT_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [2:0] slot;
    logic halt;
  } pmcc_thr_state_t;

  pmcc_thr_state_t st_reg;
  pmcc_thr_state_t st_next;

  // slot counter; halt held for duty slots out of eight
  always_comb begin
    st_next = st_reg;
    if (!run_i) begin
      st_next.cnt = '0;
      st_next.slot = 3'h0;
      st_next.halt = 1'b0;
    end else begin
      if (st_reg.cnt == SLOT_LAST) begin
        st_next.cnt = '0;
        st_next.slot = st_reg.slot + 3'h1; // wraps after eight slots
      end else begin
        st_next.cnt = st_reg.cnt + CW'(1);
      end
      // code 000 is reserved and never throttles
      st_next.halt = (duty_i != 3'h0) && (st_next.slot < duty_i);
    end
  end

  // state register, frozen while ce_i is low
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign halt_o = st_reg.halt;

endmodule

// File: verilog/pmcc_top.sv
// pm event enable and cpu clock control: registers, event gating, clock states
//
// Contract
// - cover-switch enable bit 11 gates its flag to smi, sci or resume.
// - ring enable bit 10 gates its flag to resume only.
// - gp-input enable bit 9 gates its flag to smi, sci or resume.
// - serial-bus enable bit 8 gates its flag to resume only, no interrupt.
// - thermal enable bit 0 gates its flag to smi or sci, never resume.
// - wake enable register at 0Eh, 16 bits, resets 00h, bits 15:12 and 7:1 reserved.
// - clock control register at 10h, resets 00h, bits 31:18, 16:14, 8:5 reserved.
// - read-only bit 17 shows clock control active; writes ignored.
// - clock-run enable bit 13 requests pci clock stop after 26 idle clocks.
// - halt enable bit 12 stops the host clock in level three.
// - sleep enable bit 11 asserts cpu sleep in level three.
// - burst enable set: enabled events in clock control reload burst timers.
// - burst enable clear: enabled events break level two or three out to full-speed clocking; throttling goes on.
// - level entry reads act only while clock control enable bit 9 is set.
// - throttle enable bit 4 periodically asserts stop-clock; clear means none.
// - duty field bits 3:1 gives code times 12.5 percent; 000 reserved.
// - level-two entry read enters stop-grant, returns 00h; writes do nothing.
// - level-three entry read enters stop-clock or sleep, returns 00h.
// - status flags set by hardware, cleared only by writing one.
`timescale 1ns/100ps
module pmcc_top
  import pmcc_pkg::*;
#(
  parameter int SLOT_CYCLES = PMCC_SLOT_CYCLES_DEFAULT
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // i/o register access relative to the pm base
  input wire pmcc_io_req_t io_req_i,
  output pmcc_io_rsp_t io_rsp_o,
  // status flags and routing from the rest of the pm unit
  input wire pmcc_status_t status_i,
  input wire logic sci_route_i,
  input wire logic break_event_i,
  // event outputs
  output logic system_mgmt_interrupt_n_o,
  output logic os_config_interrupt_o,
  output logic resume_event_o,
  output logic burst_reload_o,
  // processor clock pins
  output logic host_clock_halt_out_n_o,
  output logic host_clk_stop_o,
  output logic cpu_sleep_out_n_o,
  // pci clock-run pin, open drain style
  input wire logic pci_bus_idle_i,
  input wire logic pci_clock_stop_request_n_i,
  output logic pci_clock_stop_request_n_o,
  output logic pci_clock_stop_request_oe_n_o,
  output logic pci_clk_stop_o
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [15:0] wake_en;
    logic [31:0] clk_ctrl;
    pmcc_cc_state_t cc_state;
    pmcc_cr_state_t cr_state;
    logic [4:0] idle_cnt;
    logic ack;
    logic [31:0] rdata;
    logic smi;
    logic os_config_interrupt;
    logic rsm;
    logic burst;
    logic halt;
    logic host_stop;
    logic sleep;
    logic cr_out;
    logic cr_oe_n;
    logic pci_stop;
  } pmcc_state_t;

  pmcc_state_t st_reg;
  pmcc_state_t st_next;

  logic [PMCC_NUM_SRC-1:0] flag_vec;
  logic [PMCC_NUM_SRC-1:0] gated;
  logic thr_halt;
  logic thr_run;
  logic cc_active;
  logic int_req;
  logic rsm_req;
  logic sys_event;
  logic [7:0] dword;

  // ==========================================================================
  // event gating
  // ==========================================================================
  // flags stay set until software clears them, so a level here is enough
  assign flag_vec = status_i;

  // one and-gate per source, every clock
  for (genvar i = 0; i < PMCC_NUM_SRC; i++) begin : g_src
    assign gated[i] = flag_vec[i] & st_reg.wake_en[PMCC_SRC_BIT[i]];
  end

  // routing masks keep ring and serial bus off the interrupts,
  // and thermal off resume
  assign int_req = |(gated & PMCC_SRC_CAN_INT);
  assign rsm_req = |(gated & PMCC_SRC_CAN_RSM);
  assign sys_event = (|gated) | break_event_i;

  // ==========================================================================
  // throttle generator
  // ==========================================================================
  // throttling yields to the level states, which hold stop-clock anyway
  assign thr_run = st_reg.clk_ctrl[PMCC_PC_THROTTLE_BIT] &&
                   (st_reg.cc_state == PMCC_CC_RUN);

  pmcc_throttle #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_throttle (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .run_i(thr_run),
    .duty_i(st_reg.clk_ctrl[PMCC_PC_DUTY_LSB +: 3]),
    .halt_o(thr_halt)
  );

  // active while in a level state or throttling
  assign cc_active = (st_reg.cc_state != PMCC_CC_RUN) | thr_run;
  assign dword = {io_req_i.offset[7:2], 2'b00};

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    st_next = st_reg;
    st_next.ack = io_req_i.rd | io_req_i.wr;
    st_next.burst = 1'b0;

    // register writes by byte lane; reserved bits forced to zero
    if (io_req_i.wr) begin
      if (dword == PMCC_OFS_STATUS_DW) begin
        for (int b = 0; b < 2; b++) begin
          if (io_req_i.be[b+2]) begin
            st_next.wake_en[b*8 +: 8] = io_req_i.wdata[16 + b*8 +: 8];
          end
        end
        st_next.wake_en = st_next.wake_en & PMCC_WAKE_EN_MASK;
      end else if (dword == PMCC_OFS_CLK_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (io_req_i.be[b]) begin
            st_next.clk_ctrl[b*8 +: 8] = io_req_i.wdata[b*8 +: 8];
          end
        end
        // active bit and reserved bits never take written data
        st_next.clk_ctrl = st_next.clk_ctrl & PMCC_CLK_CTRL_WMASK;
      end
      // writes to the level entry lanes are dropped
    end

    // read data, unmapped and entry lanes return zero
    if (io_req_i.rd) begin
      unique case (dword)
        PMCC_OFS_STATUS_DW: begin
          // low half belongs to the status register, not driven here
          st_next.rdata = {st_reg.wake_en, 16'h0000};
        end
        PMCC_OFS_CLK_CTRL: begin
          st_next.rdata = st_reg.clk_ctrl;
          st_next.rdata[PMCC_PC_ACTIVE_BIT] = cc_active;
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // clock control state machine
    unique case (st_reg.cc_state)
      PMCC_CC_RUN: begin
        if (io_req_i.rd && (dword == PMCC_OFS_LEVEL_TWO_ENTRY) &&
            st_reg.clk_ctrl[PMCC_PC_CLOCK_CTRL_ENABLE_BIT]) begin
          // lane 1 is level three; it wins if both lanes are read
          if (io_req_i.be[1]) begin
            st_next.cc_state = PMCC_CC_LEVEL_THREE_ENTRY;
          end else if (io_req_i.be[0]) begin
            st_next.cc_state = PMCC_CC_LEVEL_TWO_ENTRY;
          end
        end
        // throttling counts as clock control for bursting
        if (thr_run && sys_event && st_reg.clk_ctrl[PMCC_PC_BURST_BIT]) begin
          st_next.burst = 1'b1;
        end
      end
      PMCC_CC_LEVEL_TWO_ENTRY, PMCC_CC_LEVEL_THREE_ENTRY: begin
        if (sys_event) begin
          if (st_reg.clk_ctrl[PMCC_PC_BURST_BIT]) begin
            st_next.burst = 1'b1;
          end else begin
            st_next.cc_state = PMCC_CC_RUN; // stop break
          end
        end
      end
    endcase

    // event request outputs, routed by the sci select
    st_next.smi = int_req & ~sci_route_i;
    st_next.os_config_interrupt = int_req & sci_route_i;
    st_next.rsm = rsm_req;

    // processor pins follow the next clock state
    st_next.halt = (st_next.cc_state != PMCC_CC_RUN) | thr_halt;
    st_next.host_stop = (st_next.cc_state == PMCC_CC_LEVEL_THREE_ENTRY) &&
                        st_reg.clk_ctrl[PMCC_PC_HALT_BIT];
    st_next.sleep = (st_next.cc_state == PMCC_CC_LEVEL_THREE_ENTRY) &&
                    st_reg.clk_ctrl[PMCC_PC_SLEEP_BIT];

    // pci clock-run: hold the pin low, count idle, then request a stop
    if (!st_reg.clk_ctrl[PMCC_PC_PCI_STOP_BIT]) begin
      st_next.cr_state = PMCC_CR_HOLD;
      st_next.idle_cnt = 5'h00;
    end else begin
      unique case (st_reg.cr_state)
        PMCC_CR_HOLD: begin
          if (!pci_bus_idle_i) begin
            st_next.idle_cnt = 5'h00;
          end else if (st_reg.idle_cnt == PMCC_PCI_IDLE_CLOCKS - 5'h01) begin
            st_next.idle_cnt = 5'h00;
            st_next.cr_state = PMCC_CR_REQ;
          end else begin
            st_next.idle_cnt = st_reg.idle_cnt + 5'h01;
          end
        end
        PMCC_CR_REQ: begin
          // one cycle driven high, then released to the pull-up
          st_next.cr_state = PMCC_CR_STOP;
        end
        PMCC_CR_STOP: begin
          // an agent pulling the pin low wants the clock back
          if (!pci_clock_stop_request_n_i) begin
            st_next.cr_state = PMCC_CR_HOLD;
          end
        end
      endcase
    end
    // pin driven low in hold, high for the request, released while stopped
    st_next.cr_oe_n = st_next.cr_state == PMCC_CR_STOP;
    st_next.cr_out = st_next.cr_state == PMCC_CR_REQ;
    // stop shown only while released and the line stays high
    st_next.pci_stop = (st_reg.cr_state == PMCC_CR_STOP) &&
                       (st_next.cr_state == PMCC_CR_STOP) &&
                       pci_clock_stop_request_n_i;
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  // reset state is constant; ce_i low freezes everything
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg.wake_en <= PMCC_WAKE_EN_RESET;
      st_reg.clk_ctrl <= PMCC_CLK_CTRL_RESET;
      st_reg.cc_state <= PMCC_CC_RUN;
      st_reg.cr_state <= PMCC_CR_HOLD;
      st_reg.idle_cnt <= 5'h00;
      st_reg.ack <= 1'b0;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.smi <= 1'b0;
      st_reg.os_config_interrupt <= 1'b0;
      st_reg.rsm <= 1'b0;
      st_reg.burst <= 1'b0;
      st_reg.halt <= 1'b0;
      st_reg.host_stop <= 1'b0;
      st_reg.sleep <= 1'b0;
      st_reg.cr_out <= 1'b0;
      st_reg.cr_oe_n <= 1'b0;
      st_reg.pci_stop <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // outputs come straight from state, so ce_i low holds them as they stand
  assign io_rsp_o.ack = st_reg.ack;
  assign io_rsp_o.rdata = st_reg.rdata;
  assign system_mgmt_interrupt_n_o = ~st_reg.smi;
  assign os_config_interrupt_o = st_reg.os_config_interrupt;
  assign resume_event_o = st_reg.rsm;
  assign burst_reload_o = st_reg.burst;
  assign host_clock_halt_out_n_o = ~st_reg.halt;
  assign host_clk_stop_o = st_reg.host_stop;
  assign cpu_sleep_out_n_o = ~st_reg.sleep;
  assign pci_clock_stop_request_n_o = st_reg.cr_out;
  assign pci_clock_stop_request_oe_n_o = st_reg.cr_oe_n;
  assign pci_clk_stop_o = st_reg.pci_stop;

endmodule

// File: sim/pmcc_top_sva.sv
// assertion checker for the pm event enable and cpu clock control block
`timescale 1ns/100ps
module pmcc_top_sva
  import pmcc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // register access
  input wire pmcc_io_req_t io_req_i,
  input wire pmcc_io_rsp_t io_rsp_o,
  // events
  input wire pmcc_status_t status_i,
  input wire logic system_mgmt_interrupt_n_o,
  input wire logic os_config_interrupt_o,
  input wire logic resume_event_o,
  // clock pins
  input wire logic host_clock_halt_out_n_o,
  input wire logic host_clk_stop_o,
  input wire logic cpu_sleep_out_n_o,
  input wire logic pci_bus_idle_i,
  input wire logic pci_clock_stop_request_n_o,
  input wire logic pci_clock_stop_request_oe_n_o,
  input wire logic pci_clk_stop_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  // ==========================================================================
  // helper logic
  // ==========================================================================
  logic [5:0] idle_run_reg;
  // idle streak, saturating so a long idle bus cannot wrap round to zero
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_run_reg <= 6'h00;
    end else if (ce_i) begin
      idle_run_reg <= !pci_bus_idle_i ? 6'h00 : idle_run_reg + {5'h00, idle_run_reg != 6'h3F};
    end
  end

  // ==========================================================================
  // properties
  // ==========================================================================
  property p_ack_next;
    (ce_i && (io_req_i.rd || io_req_i.wr)) |=> io_rsp_o.ack;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no answer one cycle after an access");
  property p_thermal_no_resume;
    (ce_i && status_i == 5'h01) |=> !resume_event_o;
  endproperty
  a_thermal_no_resume: assert property (p_thermal_no_resume)
    else $error("thermal flag alone produced a resume");
  property p_resume_only_no_int;
    (ce_i && !status_i.cover_switch_status_flag && !status_i.gp_input_status_flag
      && !status_i.thermal_status_flag) |=> system_mgmt_interrupt_n_o && !os_config_interrupt_o;
  endproperty
  a_resume_only_no_int: assert property (p_resume_only_no_int)
    else $error("resume-only source produced an interrupt");
  property p_no_flag_no_event;
    (ce_i && status_i == 5'h00) |=> !resume_event_o;
  endproperty
  a_no_flag_no_event: assert property (p_no_flag_no_event)
    else $error("resume without any flag");
  property p_level_reads_zero;
    (ce_i && io_req_i.rd && io_req_i.offset[7:2] == 6'h05) |=> io_rsp_o.rdata == 32'h0;
  endproperty
  a_level_reads_zero: assert property (p_level_reads_zero)
    else $error("level entry read returned data");
  property p_host_stop_in_halt;
    host_clk_stop_o |-> !host_clock_halt_out_n_o;
  endproperty
  a_host_stop_in_halt: assert property (p_host_stop_in_halt)
    else $error("host clock stopped outside stop-clock");
  property p_sleep_in_halt;
    !cpu_sleep_out_n_o |-> !host_clock_halt_out_n_o;
  endproperty
  a_sleep_in_halt: assert property (p_sleep_in_halt)
    else $error("sleep asserted outside stop-clock");
  property p_req_after_idle;
    (pci_clock_stop_request_n_o && !pci_clock_stop_request_oe_n_o) |-> idle_run_reg >= 6'h1A;
  endproperty
  a_req_after_idle: assert property (p_req_after_idle)
    else $error("clock stop requested before 26 idle clocks");
  property p_stop_when_released;
    $rose(pci_clk_stop_o) |-> pci_clock_stop_request_oe_n_o && $past(pci_clock_stop_request_oe_n_o);
  endproperty
  a_stop_when_released: assert property (p_stop_when_released)
    else $error("pci clock stop while pin still driven");
endmodule

// File: sim/pmcc_pci_agent.sv
// pci clock-run partner: pulled-up pin, bus activity and a clock-keeping agent
`timescale 1ns/100ps
module pmcc_pci_agent (
  // bench controls
  input wire logic busy_i,
  input wire logic keep_clk_i,
  // device side of the pin
  input wire logic drv_n_i,
  input wire logic oe_n_i,
  // resolved pin and bus state
  output logic wire_n_o,
  output logic idle_o
);
  // pull-up wins unless the device or an agent pulls low, never a stale value
  assign wire_n_o = !((!oe_n_i && !drv_n_i) || keep_clk_i);
  // idle only while no agent owns the bus
  assign idle_o = !busy_i;
endmodule

// File: sim/testbench.sv
// self-checking bench for the pm event enable and cpu clock control block
`timescale 1ns/100ps
module testbench;
  import pmcc_pkg::*;
  localparam int SLOTS = 2;
  localparam logic [4:0] INT_EXP = 5'b10101;
  localparam logic [4:0] RSM_EXP = 5'b11110;
  logic mclk_i;
  logic arst_n_i;
  logic ce;
  pmcc_io_req_t io_req;
  pmcc_io_rsp_t io_rsp;
  pmcc_status_t status;
  logic sci_route, break_ev, smi_n, os_config_interrupt, rsm, burst, halt_n, hstop, sleep_n;
  logic cr_out_n, cr_oe_n, cr_wire_n, bus_idle, pci_stop, bus_busy, agent_keep;
  logic [31:0] rd_val;
  int err_total;
  int checks_done;
  int n;

  // ==========================================================================
  // clock, device and partner
  // ==========================================================================
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // short slots keep the throttle periods brief
  pmcc_top #(.SLOT_CYCLES(SLOTS)) pmcc_top_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .ce_i(ce), .io_req_i(io_req), .io_rsp_o(io_rsp), .status_i(status),
    .sci_route_i(sci_route), .break_event_i(break_ev), .system_mgmt_interrupt_n_o(smi_n),
    .os_config_interrupt_o(os_config_interrupt), .resume_event_o(rsm), .burst_reload_o(burst),
    .host_clock_halt_out_n_o(halt_n), .host_clk_stop_o(hstop), .cpu_sleep_out_n_o(sleep_n),
    .pci_bus_idle_i(bus_idle), .pci_clock_stop_request_n_i(cr_wire_n),
    .pci_clock_stop_request_n_o(cr_out_n), .pci_clock_stop_request_oe_n_o(cr_oe_n),
    .pci_clk_stop_o(pci_stop));
  pmcc_pci_agent pmcc_pci_agent_i (.busy_i(bus_busy), .keep_clk_i(agent_keep),
    .drv_n_i(cr_out_n), .oe_n_i(cr_oe_n), .wire_n_o(cr_wire_n), .idle_o(bus_idle));

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one access pulse, then a bounded wait for the answer
  task automatic io(input logic rd, input logic [7:0] ofs, input logic [3:0] be,
    input logic [31:0] wd);
    int k;
    @(posedge mclk_i);
    io_req <= '{rd, !rd, ofs, be, wd};
    @(posedge mclk_i);
    io_req <= '0;
    k = 0;
    #1;
    while (io_rsp.ack !== 1'b1 && k < 4) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    if (k == 4) begin
      err_total++;
      $display("MISMATCH %0t: no answer", $time);
      wrap_up();
    end
    rd_val = io_rsp.rdata;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask
  task automatic pulse_break();
    @(posedge mclk_i);
    break_ev <= 1'b1;
    @(posedge mclk_i);
    break_ev <= 1'b0;
    #1;
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    arst_n_i = 1'b0;
    ce = 1'b1;
    io_req = '0;
    status = '0;
    sci_route = 1'b0;
    break_ev = 1'b0;
    bus_busy = 1'b1;
    agent_keep = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    io(1'b1, PMCC_OFS_STATUS_DW, 4'hC, 32'h0);
    check(rd_val, 32'h0, "enable reset");
    io(1'b1, PMCC_OFS_CLK_CTRL, 4'hF, 32'h0);
    check(rd_val, 32'h0, "control reset");
    io(1'b1, 8'h40, 4'hF, 32'h0);
    check(rd_val, 32'h0, "unmapped read");
    io(1'b0, PMCC_OFS_STATUS_DW, 4'hC, 32'hFFFF_FFFF);
    io(1'b1, PMCC_OFS_STATUS_DW, 4'hC, 32'h0);
    check(rd_val, 32'h0F01_0000, "enable reserved bits");
    // each source alone, both interrupt routes; flags stand until cleared here
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_i);
      status <= 5'(1 << (i / 2));
      sci_route <= i[0];
      cyc(3);
      check(rsm, RSM_EXP[i / 2], "resume");
      check(os_config_interrupt, i[0] & INT_EXP[i / 2], "config interrupt");
      check(smi_n, !(!i[0] & INT_EXP[i / 2]), "mgmt interrupt");
    end
    io(1'b0, PMCC_OFS_STATUS_DW, 4'hC, 32'h0);
    @(posedge mclk_i);
    status <= 5'h1F;
    sci_route <= 1'b0;
    cyc(3);
    check({rsm, smi_n}, 32'h1, "disabled sources");
    @(posedge mclk_i);
    status <= 5'h00;
    // duty sweep; reserved bits and the status bit are written and must not stick
    for (int d = 0; d < 8; d++) begin
      io(1'b0, PMCC_OFS_CLK_CTRL, 4'hF, 32'hFFFF_C1F0 | 32'(d << 1));
      cyc(4);
      n = 0;
      repeat (8 * SLOTS) begin
        @(posedge mclk_i);
        #1;
        n += (halt_n === 1'b0);
      end
      check(n, d * SLOTS, "throttle low cycles");
    end
    io(1'b1, PMCC_OFS_CLK_CTRL, 4'hF, 32'h0);
    check(rd_val, 32'h0002_001E, "control while throttling");
    io(1'b0, PMCC_OFS_CLK_CTRL, 4'hF, 32'h0000_000E);
    io(1'b1, PMCC_OFS_LEVEL_TWO_ENTRY, 4'h2, 32'h0);
    cyc(2 * 8 * SLOTS);
    check({halt_n, rd_val}, {1'b1, 32'h0}, "throttle off, entry disabled");
    io(1'b1, PMCC_OFS_CLK_CTRL, 4'hF, 32'h0);
    check(rd_val, 32'h0E, "control idle");
    // level three with stop and sleep, left by a stop-break event
    io(1'b0, PMCC_OFS_CLK_CTRL, 4'hF, 32'h1A00);
    io(1'b1, PMCC_OFS_LEVEL_TWO_ENTRY, 4'h2, 32'h0);
    cyc(1);
    check({rd_val, halt_n, hstop, sleep_n}, 35'h2, "level three");
    io(1'b1, PMCC_OFS_CLK_CTRL, 4'hF, 32'h0);
    check(rd_val, 32'h0002_1A00, "clock control active");
    // a frozen block must miss the event and stay in level three
    @(posedge mclk_i);
    ce <= 1'b0;
    pulse_break();
    cyc(2);
    check(halt_n, 32'h0, "frozen while disabled");
    @(posedge mclk_i);
    ce <= 1'b1;
    pulse_break();
    cyc(2);
    check({halt_n, sleep_n}, 32'h3, "stop break");
    // level two with bursting, then left once bursting is cleared
    io(1'b0, PMCC_OFS_CLK_CTRL, 4'hF, 32'h0600);
    io(1'b1, PMCC_OFS_LEVEL_TWO_ENTRY, 4'h1, 32'h0);
    cyc(1);
    check({rd_val, halt_n, hstop, sleep_n}, 35'h1, "level two");
    pulse_break();
    check(burst, 32'h1, "burst reload");
    cyc(2);
    check(halt_n, 32'h0, "burst keeps clock control");
    io(1'b0, PMCC_OFS_CLK_CTRL, 4'hF, 32'h0200);
    pulse_break();
    cyc(2);
    check(halt_n, 32'h1, "break after burst off");
    // clock run: idle bus, release, then an agent keeps the clock
    io(1'b0, PMCC_OFS_CLK_CTRL, 4'hF, 32'h2000);
    @(posedge mclk_i);
    bus_busy <= 1'b0;
    n = 0;
    while (cr_oe_n !== 1'b1 && n < 60) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    check(n >= 27 && n < 60, 32'h1, "release after idle");
    if (n == 60) begin
      wrap_up();
    end
    cyc(3);
    check(pci_stop, 32'h1, "pci clock stop");
    @(posedge mclk_i);
    agent_keep <= 1'b1;
    cyc(3);
    check({cr_oe_n, cr_out_n, pci_stop}, 32'h0, "clock kept running");
    wrap_up();
  end
endmodule

bind pmcc_top pmcc_top_sva pmcc_top_sva_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
  .io_req_i(io_req_i), .io_rsp_o(io_rsp_o), .status_i(status_i),
  .system_mgmt_interrupt_n_o(system_mgmt_interrupt_n_o),
  .os_config_interrupt_o(os_config_interrupt_o), .resume_event_o(resume_event_o),
  .host_clock_halt_out_n_o(host_clock_halt_out_n_o), .host_clk_stop_o(host_clk_stop_o),
  .cpu_sleep_out_n_o(cpu_sleep_out_n_o), .pci_bus_idle_i(pci_bus_idle_i),
  .pci_clock_stop_request_n_o(pci_clock_stop_request_n_o),
  .pci_clock_stop_request_oe_n_o(pci_clock_stop_request_oe_n_o),
  .pci_clk_stop_o(pci_clk_stop_o));
